// >>> design/octr_ctrl.sv
`timescale 1ns/1ps
`include "octr_regs.svh"
// Function
// - Above fast-trip level trips at once, unfiltered
// - Fast-trip choices off/60/100/200 mV, default 100
// - Regulation active in soft start and normal
// - Between 50 mV and trip level, regulate
// - Regulation timer 5/80/320 ms, starts with regulation
// - Timer expiry or fast trip drops outputs
// - Below 50 mV before expiry clears timer
// - Fast trip during regulation bypasses timer
// - Regulation disabled after reset by default
// - Without regulation, trip after filter delay
// - Drain sense ignored while regulating
module octr_ctrl
	import octr_pkg::*;
#(
	parameter int FILTER_US = `OCTR_FD_DEF_US,      // Breaker filter delay
	parameter int MS_CYCLES = `OCTR_MS_CYCLES       // Cycles per ms, shortenable
) (
	input  wire logic       CORE_CLK,
	input  wire logic       RST,
	input  wire logic       START,           // Power-up sequence enable
	input  wire logic       ABOVE_50MV,      // Breaker_sense above 50 mV
	input  wire logic       ABOVE_TRIP,      // Above fast_trip_threshold
	input  wire logic       DRAIN_OK,        // Drain sense below limit
	input  wire logic       PG_READY,        // Power-good delay elapsed
	input  wire logic       CFG_WR,          // Configuration load strobe
	input  wire logic [1:0] CFG_FAST_TRIP,   // Fast-trip level select
	input  wire logic       CFG_REG_EN,      // Regulation select
	input  wire logic [1:0] CFG_REG_TIME,    // Regulation limit select
	output logic      [1:0] FAST_TRIP_SEL,   // To analog threshold mux
	output logic            GATE_DRIVE,      // Gate drive enable
	output logic            GATE_REDUCE,     // Regulation loop engage
	output logic            POWER_GOOD_N,    // Active-low power good
	output logic            TRIPPED          // Breaker tripped flag
);
	localparam int FILT_CYC = (FILTER_US * `OCTR_CLK_MHZ < 1) ? 1 :
		FILTER_US * `OCTR_CLK_MHZ;  // Least time, whole cycles
	localparam int CW = `OCTR_CNT_W;

	octr_cmp_t   cmp;        // Synchronised comparator pair
	octr_cfg_t   cfg_q;      // Held configuration
	octr_cfg_t   cfg_d;
	octr_state_t state_q;    // Protection state
	octr_state_t state_d;
	logic [CW-1:0] cnt_q;    // Filter or regulation timer
	logic [CW-1:0] cnt_d;
	logic [CW-1:0] limit;    // Regulation limit in cycles
	logic        run_q;      // Controller powered up
	logic        gate_q;
	logic        reduce_q;
	logic        pg_n_q;
	logic        trip_q;

	// Synchronise analog comparator outputs
	octr_sync #(.W(2)) u_sync (
		.clk   (CORE_CLK),
		.rst   (RST),
		.d_in  ({ABOVE_50MV, ABOVE_TRIP}),
		.d_out ({cmp.above_50mv, cmp.above_trip})
	);

	// Configuration load; selects are clamped to legal codes
	wire [1:0] rt_sel = (CFG_REG_TIME > `OCTR_RT_320MS) ?
		`OCTR_RT_320MS : CFG_REG_TIME;
	assign cfg_d = CFG_WR ? octr_cfg_t'{CFG_FAST_TRIP, CFG_REG_EN, rt_sel}
		: cfg_q;

	// Regulation limit by select
	wire [CW-1:0] lim_5   = CW'(`OCTR_RT_5MS_TIME * MS_CYCLES);
	wire [CW-1:0] lim_80  = CW'(`OCTR_RT_80MS_TIME * MS_CYCLES);
	wire [CW-1:0] lim_320 = CW'(`OCTR_RT_320MS_TIME * MS_CYCLES);
	assign limit = (cfg_q.reg_time_sel == `OCTR_RT_5MS)  ? lim_5 :
		(cfg_q.reg_time_sel == `OCTR_RT_80MS) ? lim_80 : lim_320;

	// Decode of the current conditions
	wire fast_hit = cmp.above_trip &&
		(cfg_q.fast_trip_sel != `OCTR_FT_OFF);
	wire over_50  = cmp.above_50mv;
	wire filt_done = (cnt_q >= CW'(FILT_CYC));
	wire reg_done  = (cnt_q >= limit);
	wire [CW-1:0] cnt_inc = cnt_q + CW'(1);  // Timer step, never wraps

	// Next state; fast trip has top priority once the run latch is set
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		unique case (state_q)
			OCTR_NORMAL: begin
				cnt_d = '0;
				if (!run_q)
					state_d = OCTR_NORMAL;
				else if (fast_hit)
					state_d = OCTR_TRIPPED;
				else if (over_50 && cfg_q.reg_enable)
					state_d = OCTR_REGULATE;
				else if (over_50)
					state_d = OCTR_FILTER;
			end
			OCTR_FILTER: begin
				cnt_d = cnt_inc;
				if (fast_hit)
					state_d = OCTR_TRIPPED;
				else if (!over_50)
					state_d = OCTR_NORMAL;
				else if (filt_done)
					state_d = OCTR_TRIPPED;
			end
			OCTR_REGULATE: begin
				cnt_d = cnt_inc;
				if (fast_hit)
					state_d = OCTR_TRIPPED;
				else if (!over_50)
					state_d = OCTR_NORMAL;
				else if (reg_done)
					state_d = OCTR_TRIPPED;
			end
			OCTR_TRIPPED: begin
				cnt_d   = '0;
				state_d = OCTR_TRIPPED;
			end
		endcase
	end

	// Outputs decoded from the next state, so they register on entry
	wire nxt_trip = (state_d == OCTR_TRIPPED);
	wire nxt_reg  = (state_d == OCTR_REGULATE);
	wire gate_d   = run_q && !nxt_trip;
	// Drain sense does not count while regulating, exit cycle included,
	// so a drain still settling cannot flicker power good on recovery
	wire in_reg   = nxt_reg || (state_q == OCTR_REGULATE);
	wire drain_ok = in_reg ? 1'b1 : DRAIN_OK;
	wire pg_n_d   = !(gate_d && PG_READY && drain_ok);

	// Configuration and run latch; restart only through reset
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			cfg_q <= '{`OCTR_FT_RESET, 1'b0, `OCTR_RT_5MS};
			run_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			run_q <= run_q || (START && !nxt_trip);
		end
	end

	// State and timer
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= OCTR_NORMAL;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Registered outputs; trip forces both off at once
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			gate_q   <= 1'b0;
			reduce_q <= 1'b0;
			pg_n_q   <= 1'b1;
			trip_q   <= 1'b0;
		end else begin
			gate_q   <= gate_d;
			reduce_q <= nxt_reg;
			pg_n_q   <= pg_n_d;
			trip_q   <= nxt_trip;
		end
	end

	// Threshold select follows the held configuration
	logic [1:0] ft_q;
	always_ff @(posedge CORE_CLK) begin
		if (RST)
			ft_q <= `OCTR_FT_RESET;
		else
			ft_q <= cfg_q.fast_trip_sel;
	end

	assign FAST_TRIP_SEL = ft_q;
	assign GATE_DRIVE    = gate_q;
	assign GATE_REDUCE   = reduce_q;
	assign POWER_GOOD_N  = pg_n_q;
	assign TRIPPED       = trip_q;

endmodule : octr_ctrl

// >>> design/octr_regs.svh
`ifndef OCTR_REGS_SVH
`define OCTR_REGS_SVH

// Fast-trip level select codes
`define OCTR_FT_OFF        2'h0
`define OCTR_FT_60MV       2'h1
`define OCTR_FT_100MV      2'h2
`define OCTR_FT_200MV      2'h3
`define OCTR_FT_RESET      2'h2

// Regulation time limit select codes
`define OCTR_RT_5MS        2'h0
`define OCTR_RT_80MS       2'h1
`define OCTR_RT_320MS      2'h2

// Times in their own units
`define OCTR_CLK_MHZ       50
`define OCTR_MS_CYCLES     (1000 * `OCTR_CLK_MHZ)
`define OCTR_RT_5MS_TIME   5
`define OCTR_RT_80MS_TIME  80
`define OCTR_RT_320MS_TIME 320
`define OCTR_FD_DEF_US     50

// Counter width, enough for 320 ms at 50 MHz
`define OCTR_CNT_W         25

`endif

// >>> design/octr_pkg.sv
package octr_pkg;

	// Synchronised comparator results
	typedef struct packed {
		logic above_50mv;   // Sense above 50 mV
		logic above_trip;   // Sense above selected fast-trip level
	} octr_cmp_t;

	// Configuration from the programming port
	typedef struct packed {
		logic [1:0] fast_trip_sel;  // Fast-trip level choice
		logic       reg_enable;     // Current regulation selected
		logic [1:0] reg_time_sel;   // Regulation time limit choice
	} octr_cfg_t;

	// Protection states, Gray code in listed order
	typedef enum logic [1:0] {
		OCTR_NORMAL  = 2'b00,
		OCTR_FILTER  = 2'b01,
		OCTR_REGULATE = 2'b11,
		OCTR_TRIPPED = 2'b10
	} octr_state_t;

endpackage : octr_pkg

// >>> design/octr_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser per bit, generate loop
module octr_sync
	import octr_pkg::*;
#(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] d_out
);
	logic [W-1:0] meta_q;  // First stage, read only by second

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// Two stages; first feeds only the second
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q[i] <= 1'b0;
					d_out[i]  <= 1'b0;
				end else begin
					meta_q[i] <= d_in[i];
					d_out[i]  <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule : octr_sync

// >>> testbench/octr_ctrl_asserts.sv
`timescale 1ns/1ps
// Ties each protection output to its cause at the ports
module octr_asserts
	import octr_pkg::*;
#(
	parameter int FILTER_US = 50,
	parameter int MS_CYCLES = 50000
) (
	input wire logic       CORE_CLK,
	input wire logic       RST,
	input wire logic       START,
	input wire logic       ABOVE_50MV,
	input wire logic       ABOVE_TRIP,
	input wire logic       CFG_WR,
	input wire logic       PG_READY,
	input wire logic [1:0] FAST_TRIP_SEL,
	input wire logic       GATE_DRIVE,
	input wire logic       GATE_REDUCE,
	input wire logic       POWER_GOOD_N,
	input wire logic       TRIPPED
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	localparam int REG_MAX = 320 * MS_CYCLES + 4; // Longest limit plus sync
	int unsigned reg_q; // Cycles spent regulating in a row
	// Counter restarts whenever regulation ends
	always_ff @(posedge CORE_CLK) begin
		reg_q <= (RST || !GATE_REDUCE) ? 0 : reg_q + 1;
	end
	// Armed fast trip seen over its level
	sequence over_trip_s;
		ABOVE_TRIP && FAST_TRIP_SEL != 2'h0 && GATE_DRIVE;
	endsequence
	ft_trip_a: assert property (over_trip_s [*3] |-> ##[1:2] TRIPPED)
		else $error("fast trip late");
	trip_hold_a: assert property (TRIPPED |=> TRIPPED)
		else $error("trip released");
	trip_off_a: assert property (TRIPPED |-> !GATE_DRIVE && POWER_GOOD_N)
		else $error("outputs on while tripped");
	reduce_gate_a: assert property (GATE_REDUCE |-> GATE_DRIVE && !TRIPPED)
		else $error("regulating without gate");
	pg_gate_a: assert property (!POWER_GOOD_N |-> GATE_DRIVE)
		else $error("power good without gate");
	gate_on_a: assert property ($rose(START) |-> ##[1:3] GATE_DRIVE)
		else $error("gate not turned on");
	reg_end_a: assert property ($fell(ABOVE_50MV) && GATE_REDUCE && !ABOVE_TRIP
		|-> ##[1:4] !GATE_REDUCE)
		else $error("regulation not ended");
	reg_limit_a: assert property (reg_q <= REG_MAX)
		else $error("regulation too long");
	sel_hold_a: assert property (!CFG_WR [*3] |=> $stable(FAST_TRIP_SEL))
		else $error("select changed unasked");
	pg_reg_a: assert property (GATE_REDUCE && PG_READY |=> !POWER_GOOD_N || TRIPPED)
		else $error("power good lost while regulating");
endmodule : octr_asserts
bind octr_ctrl octr_asserts #(.FILTER_US(FILTER_US), .MS_CYCLES(MS_CYCLES))
	u_chk (.CORE_CLK, .RST, .START, .ABOVE_50MV, .ABOVE_TRIP, .CFG_WR, .PG_READY,
	.FAST_TRIP_SEL, .GATE_DRIVE, .GATE_REDUCE, .POWER_GOOD_N, .TRIPPED);

// >>> testbench/octr_load.sv
`timescale 1ns/1ps
// Gate driver and converter side of the switch
module octr_load (
	input  wire logic clk,
	input  wire logic gate_on,
	input  wire logic reduce,
	output logic      pg_ready,
	output logic      drain_ok
);
	logic [2:0] on_q; // Cycles the gate has been on
	// Saturates so a long run never wraps
	always_ff @(posedge clk) begin
		on_q <= gate_on ? (on_q == 3'h7 ? on_q : on_q + 3'h1) : 3'h0;
	end
	// Gate reaches its threshold after a few cycles
	assign pg_ready = (on_q >= 3'h4);
	// A throttled gate lifts the drain out of range
	assign drain_ok = pg_ready && !reduce;
endmodule : octr_load

// >>> testbench/octr_ctrl_tb.sv
`timescale 1ns/1ps
module octr_ctrl_tb;
	import octr_pkg::*;
	logic       clk, rst = 1, start = 0, a50 = 0, atr = 0, wr = 0, en = 0;
	logic [1:0] ft = 0, rt = 0, sel;
	logic       gate, red, pgn, trp, pgr, dok;
	int         bad_count = 0, tests_run = 0, cyc = 0, n;
	logic [3:0] q[$]; // Expected {gate, reduce, pg_n, tripped}
	event       smp;
	octr_ctrl #(.FILTER_US(1), .MS_CYCLES(10)) DUT (.CORE_CLK(clk),
		.RST(rst), .START(start), .ABOVE_50MV(a50), .ABOVE_TRIP(atr),
		.DRAIN_OK(dok), .PG_READY(pgr), .CFG_WR(wr), .CFG_FAST_TRIP(ft),
		.CFG_REG_EN(en), .CFG_REG_TIME(rt), .FAST_TRIP_SEL(sel),
		.GATE_DRIVE(gate), .GATE_REDUCE(red), .POWER_GOOD_N(pgn),
		.TRIPPED(trp));
	octr_load PEER (.clk(clk), .gate_on(gate), .reduce(red),
		.pg_ready(pgr), .drain_ok(dok));
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	task step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	task finish_test;
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	task flag(input string m);
		bad_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask : flag
	task cmp_out(input logic [3:0] e);
		tests_run++;
		if ({gate, red, pgn, trp} !== e) flag("output state");
	endtask : cmp_out
	task cmp_sel(input logic [1:0] e);
		tests_run++;
		if (sel !== e) flag("trip select");
	endtask : cmp_sel
	task note(input logic [3:0] e);
		q.push_back(e);
		->smp;
	endtask : note
	// Watcher takes the oldest note when a sample is due
	always @(smp) cmp_out(q.pop_front());
	// Hang guard
	always @(posedge clk) begin
		if (++cyc > 20000) begin
			bad_count++;
			finish_test();
		end
	end
	// Reset, load the setup, start power-up
	task go(input logic [1:0] f, input logic e, input logic [1:0] t);
		rst = 1; start = 0; a50 = 0; atr = 0;
		step(8);
		rst = 0; ft = f; en = e; rt = t; wr = 1;
		step(1);
		wr = 0; start = 1;
		step(3);
	endtask : go
	initial begin
		void'($urandom(70126));
		// Defaults: no regulation, filtered breaker
		step(8);
		rst = 0;
		step(1);
		cmp_sel(2'h2);
		start = 1;
		step(3);
		a50 = 1;
		step($urandom_range(40, 10));
		a50 = 0;
		step(4);
		note(4'h8);
		a50 = 1;
		step(44);
		note(4'h8);
		step(14);
		note(4'h3);
		$display("test 1 done");
		// Fast trip at each level cuts regulation short
		for (int f = 1; f < 4; f++) begin
			go(f[1:0], 1'b1, 2'h2);
			a50 = 1;
			step(6);
			note(4'hC);
			atr = 1;
			step(4);
			note(4'h3);
			atr = 0; a50 = 0;
			step(5);
			note(4'h3);
			cmp_sel(f[1:0]);
		end
		$display("test 2 done");
		// Disabled fast trip is ignored
		go(2'h0, 1'b0, 2'h0);
		atr = 1;
		step(8);
		note(4'h8);
		$display("test 3 done");
		// Each regulation limit, drain bad meanwhile; code 3 means 320 ms
		for (int t = 0; t < 4; t++) begin
			n = (t == 0) ? 50 : (t == 1) ? 800 : 3200;
			go(2'h2, 1'b1, t[1:0]);
			a50 = 1;
			step(n - 2);
			note(4'hC);
			step(8);
			note(4'h3);
		end
		$display("test 4 done");
		// Recovery clears the timer, after power good
		go(2'h2, 1'b1, 2'h0);
		step(10);
		a50 = 1;
		step($urandom_range(44, 20));
		a50 = 0;
		step(6);
		note(4'h8);
		a50 = 1;
		step(40);
		note(4'hC);
		step(20);
		note(4'h3);
		$display("test 5 done");
		finish_test();
	end
endmodule : octr_ctrl_tb
